// *** btw_defines.svh ***
// Register offsets, field positions, reset values and divider taps of the basic timer and watchdog control.
`ifndef BTW_DEFINES_SVH
`define BTW_DEFINES_SVH

`define BTW_ADDR_CTRL      8'hDC
`define BTW_ADDR_STATUS    8'hE0

`define BTW_CTRL_RESET     8'h00
`define BTW_WDT_MSB        7
`define BTW_WDT_LSB        4
`define BTW_WDT_OFF_CODE   4'hA
`define BTW_SEL_MSB        3
`define BTW_SEL_LSB        2
`define BTW_CNT_CLR_BIT    1
`define BTW_DIV_CLR_BIT    0

`define BTW_STAT_WDT_BIT   8

`define BTW_RESP_OKAY      2'h0
`define BTW_RESP_SLVERR    2'h2

`define BTW_TAP_4096       12
`define BTW_TAP_1024       10
`define BTW_TAP_128        7
`define BTW_TAP_16         4

`endif

// *** btw_pkg.sv ***
// Types shared by the basic timer and watchdog control block.
package btw_pkg;

	typedef enum logic [1:0] {
		BTW_SEL_DIV4096 = 2'b00,
		BTW_SEL_DIV1024 = 2'b01,
		BTW_SEL_DIV128  = 2'b10,
		BTW_SEL_DIV16   = 2'b11
	} btw_clksel_e;

	typedef enum logic [0:0] {
		BTW_WR_IDLE = 1'b0,
		BTW_WR_RESP = 1'b1
	} btw_wr_state_e;

	typedef enum logic [0:0] {
		BTW_RD_IDLE = 1'b0,
		BTW_RD_DATA = 1'b1
	} btw_rd_state_e;

	typedef logic [7:0] btw_byte_t;

endpackage

// *** btw_prescaler.sv ***
// Shared clock frequency divider with one tick output per selectable ratio.
`timescale 1ns/1ps
`include "btw_defines.svh"

module btw_prescaler #(
	parameter int WIDTH = `BTW_TAP_4096
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clear,
	output logic [WIDTH-1:0]      div_count,
	output logic [3:0]            div_tick
);
	import btw_pkg::*;

	logic [WIDTH-1:0] div_r;
	logic [WIDTH-1:0] div_nxt;

	function automatic int tap_bits(input int idx);
		case (idx)
			0: tap_bits = `BTW_TAP_4096;
			1: tap_bits = `BTW_TAP_1024;
			2: tap_bits = `BTW_TAP_128;
			default: tap_bits = `BTW_TAP_16;
		endcase
	endfunction

	always_comb begin
		if (clear) begin
			div_nxt = '0;
		end else begin
			div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	assign div_count = div_r;

	// A tap fires once every 2**bits cycles, when its low bits are all ones; a clear restarts every tap.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tap
			localparam int BITS = tap_bits(gi);
			assign div_tick[gi] = !clear && (&div_r[BITS-1:0]);
		end
	endgenerate

endmodule

// *** btw_counter.sv ***
// Basic timer counter that advances on the selected divider tick.
`timescale 1ns/1ps

module btw_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                clear,
	input  wire btw_pkg::btw_clksel_e sel,
	input  wire logic [3:0]          div_tick,
	output logic [WIDTH-1:0]         count
);
	import btw_pkg::*;

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic             tick;

	always_comb begin
		unique case (sel)
			BTW_SEL_DIV4096: tick = div_tick[0];
			BTW_SEL_DIV1024: tick = div_tick[1];
			BTW_SEL_DIV128:  tick = div_tick[2];
			BTW_SEL_DIV16:   tick = div_tick[3];
		endcase
		if (clear) begin
			cnt_nxt = '0;
		end else if (tick) begin
			cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign count = cnt_r;

endmodule

// *** btw_top.sv ***
// Basic timer and watchdog control register with its AXI4-Lite slave, divider and counter.
`timescale 1ns/1ps
`include "btw_defines.svh"

module btw_top #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 8,
	parameter int DIV_W  = `BTW_TAP_4096
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic                      wdt_enable,
	output btw_pkg::btw_clksel_e      bt_clk_sel,
	output logic [CNT_W-1:0]          bt_count,
	output logic                      bt_count_clear,
	output logic                      div_clear,
	output logic [DIV_W-1:0]          div_count,
	output logic [3:0]                div_tick
);
	import btw_pkg::*;

	// Write channel state.
	btw_wr_state_e     wr_state_r;
	btw_wr_state_e     wr_state_nxt;
	logic              aw_held_r;
	logic              aw_held_nxt;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [ADDR_W-1:0] aw_addr_nxt;
	logic              w_held_r;
	logic              w_held_nxt;
	btw_byte_t         w_data_r;
	btw_byte_t         w_data_nxt;
	logic              w_lane0_r;
	logic              w_lane0_nxt;
	logic [1:0]        bresp_r;
	logic [1:0]        bresp_nxt;

	// Control state.
	logic [5:0]        ctrl_hi_r;
	logic [5:0]        ctrl_hi_nxt;
	logic              cnt_clr_r;
	logic              cnt_clr_nxt;
	logic              div_clr_r;
	logic              div_clr_nxt;

	// Read channel state.
	btw_rd_state_e     rd_state_r;
	btw_rd_state_e     rd_state_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic [1:0]        rresp_r;
	logic [1:0]        rresp_nxt;

	logic              wr_fire;
	logic              wr_hit_ctrl;
	logic              wr_hit_stat;
	logic              ar_fire;
	btw_byte_t         ctrl_view;
	logic [CNT_W-1:0]  cnt_value;
	logic              ctrl_wr;
	logic              wdt_en_r;
	logic              wdt_en_nxt;

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] target);
		addr_is = (a[7:2] == target[7:2]);
	endfunction

	// Only the exact code turns the watchdog off, so a corrupted nibble fails safe with it running.
	function automatic logic wdt_code_enables(input logic [3:0] code);
		wdt_code_enables = (code != `BTW_WDT_OFF_CODE);
	endfunction

	// The status word is a snapshot taken at the edge that accepts the read address.
	function automatic logic [31:0] status_word(input logic [CNT_W-1:0] cnt, input logic wdt_on);
		status_word                    = 32'h0000_0000;
		status_word[CNT_W-1:0]         = cnt;
		status_word[`BTW_STAT_WDT_BIT] = wdt_on;
	endfunction

	// The strobe bits are not kept in ctrl_hi_r, so every read of the control register shows them as zero.
	assign ctrl_view = {ctrl_hi_r, 2'b00};

	assign s_axi_awready = (wr_state_r == BTW_WR_IDLE) && !aw_held_r;
	assign s_axi_wready  = (wr_state_r == BTW_WR_IDLE) && !w_held_r;
	assign s_axi_bvalid  = (wr_state_r == BTW_WR_RESP);
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = (rd_state_r == BTW_RD_IDLE);
	assign s_axi_rvalid  = (rd_state_r == BTW_RD_DATA);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	assign wr_fire     = (wr_state_r == BTW_WR_IDLE) && aw_held_r && w_held_r;
	assign wr_hit_ctrl = addr_is(aw_addr_r, `BTW_ADDR_CTRL);
	assign wr_hit_stat = addr_is(aw_addr_r, `BTW_ADDR_STATUS);
	assign ar_fire     = s_axi_arvalid && s_axi_arready;

	// A write with byte lane 0 off still completes, but leaves the control bits alone.
	assign ctrl_wr = wr_fire && wr_hit_ctrl && w_lane0_r;

	// Write address and data are parked independently; the register is updated once both are in hand.
	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_addr_nxt = aw_addr_r;
		w_held_nxt  = w_held_r;
		w_data_nxt  = w_data_r;
		w_lane0_nxt = w_lane0_r;
		// A channel refuses a second beat until the parked one is used, so one write is under way at a time.
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt  = 1'b1;
			w_data_nxt  = s_axi_wdata[7:0];
			w_lane0_nxt = s_axi_wstrb[0];
		end
		// Both parked beats are consumed by the write that they complete.
		if (wr_fire) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_held_r  <= 1'b0;
			w_data_r  <= 8'h00;
			w_lane0_r <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_held_r  <= w_held_nxt;
			w_data_r  <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
		end
	end

	// The response depends on the parked address alone, so a write with no byte lane still answers OKAY.
	always_comb begin
		wr_state_nxt = wr_state_r;
		bresp_nxt    = bresp_r;
		unique case (wr_state_r)
			BTW_WR_IDLE: begin
				if (wr_fire) begin
					wr_state_nxt = BTW_WR_RESP;
					if (wr_hit_ctrl) begin
						bresp_nxt = `BTW_RESP_OKAY;
					end else if (wr_hit_stat) begin
						bresp_nxt = `BTW_RESP_OKAY;
					end else begin
						bresp_nxt = `BTW_RESP_SLVERR;
					end
				end
			end
			BTW_WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_nxt = BTW_WR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_state_r <= BTW_WR_IDLE;
			bresp_r    <= `BTW_RESP_OKAY;
		end else begin
			wr_state_r <= wr_state_nxt;
			bresp_r    <= bresp_nxt;
		end
	end

	// Control group: the upper six bits are kept, while the two clear strobes live for exactly one cycle.
	always_comb begin
		ctrl_hi_nxt = ctrl_hi_r;
		cnt_clr_nxt = 1'b0;
		div_clr_nxt = 1'b0;
		if (ctrl_wr) begin
			ctrl_hi_nxt = w_data_r[`BTW_WDT_MSB:`BTW_SEL_LSB];
			cnt_clr_nxt = w_data_r[`BTW_CNT_CLR_BIT];
			div_clr_nxt = w_data_r[`BTW_DIV_CLR_BIT];
		end
		// Decoding the next value lets the enable leave a flop in the same cycle as the stored code.
		wdt_en_nxt = wdt_code_enables(ctrl_hi_nxt[`BTW_WDT_MSB-`BTW_SEL_LSB:`BTW_WDT_LSB-`BTW_SEL_LSB]);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_hi_r <= 6'(`BTW_CTRL_RESET >> `BTW_SEL_LSB);
			cnt_clr_r <= 1'b0;
			div_clr_r <= 1'b0;
			// The cleared code is not the off code, so the watchdog comes out of reset enabled.
			wdt_en_r  <= 1'b1;
		end else begin
			ctrl_hi_r <= ctrl_hi_nxt;
			cnt_clr_r <= cnt_clr_nxt;
			div_clr_r <= div_clr_nxt;
			wdt_en_r  <= wdt_en_nxt;
		end
	end

	// Read answers come one cycle after the address is taken and hold until rready.
	always_comb begin
		rd_state_nxt = rd_state_r;
		rdata_nxt    = rdata_r;
		rresp_nxt    = rresp_r;
		unique case (rd_state_r)
			BTW_RD_IDLE: begin
				if (ar_fire) begin
					rd_state_nxt = BTW_RD_DATA;
					rresp_nxt    = `BTW_RESP_OKAY;
					rdata_nxt    = 32'h0000_0000;
					if (addr_is(s_axi_araddr, `BTW_ADDR_CTRL)) begin
						rdata_nxt[7:0] = ctrl_view;
					end else if (addr_is(s_axi_araddr, `BTW_ADDR_STATUS)) begin
						rdata_nxt = status_word(cnt_value, wdt_enable);
					end else begin
						rresp_nxt = `BTW_RESP_SLVERR;
					end
				end
			end
			BTW_RD_DATA: begin
				if (s_axi_rready) begin
					rd_state_nxt = BTW_RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_state_r <= BTW_RD_IDLE;
			rdata_r    <= 32'h0000_0000;
			rresp_r    <= `BTW_RESP_OKAY;
		end else begin
			rd_state_r <= rd_state_nxt;
			rdata_r    <= rdata_nxt;
			rresp_r    <= rresp_nxt;
		end
	end

	assign wdt_enable = wdt_en_r;
	assign bt_clk_sel = btw_clksel_e'(ctrl_hi_r[`BTW_SEL_MSB-`BTW_SEL_LSB:0]);

	assign bt_count_clear = cnt_clr_r;
	assign div_clear      = div_clr_r;
	assign bt_count       = cnt_value;

	// The same divider feeds the timer/counters through div_count and div_tick, so its clear reaches them.
	btw_prescaler #(
		.WIDTH     (DIV_W)
	) u_prescaler (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clear     (div_clr_r),
		.div_count (div_count),
		.div_tick  (div_tick)
	);

	btw_counter #(
		.WIDTH    (CNT_W)
	) u_counter (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.clear    (cnt_clr_r),
		.sel      (bt_clk_sel),
		.div_tick (div_tick),
		.count    (cnt_value)
	);

endmodule

// *** btw_top_monitor.sv ***
// Assertion checker for the basic timer and watchdog control block, bound to its top module.
`timescale 1ns/1ps
`include "btw_defines.svh"
module btw_top_monitor #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 8,
	parameter int DIV_W  = 12
) (
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic [31:0]          s_axi_wdata,
	input wire logic [3:0]           s_axi_wstrb,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic                 s_axi_bvalid,
	input wire logic [ADDR_W-1:0]    s_axi_araddr,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 s_axi_rvalid,
	input wire logic                 wdt_enable,
	input wire btw_pkg::btw_clksel_e bt_clk_sel,
	input wire logic [CNT_W-1:0]     bt_count,
	input wire logic                 bt_count_clear,
	input wire logic                 div_clear,
	input wire logic [DIV_W-1:0]     div_count,
	input wire logic [3:0]           div_tick
);
	import btw_pkg::*;
	logic [ADDR_W-1:0] aw_q;
	logic [ADDR_W-1:0] ar_q;
	logic [7:0]        wd_q;
	logic              ws_q;
	logic              wr_ctrl;
	logic              rd_ctrl;
	// Capture the accepted request so the answer edge can be tied back to what was asked.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_q <= '0;
			ar_q <= '0;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
			if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
			if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
		end
	end
	assign wr_ctrl = (aw_q[7:2] == 6'h37) && ws_q;
	assign rd_ctrl = (ar_q[7:2] == 6'h37);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_wdt_code: assert property ($rose(s_axi_bvalid) && wr_ctrl |-> wdt_enable == (wd_q[7:4] != 4'hA))
		else $error("watchdog enable does not follow written code");
	chk_clk_select: assert property ($rose(s_axi_bvalid) && wr_ctrl |-> bt_clk_sel == wd_q[3:2])
		else $error("clock select does not follow written bits");
	chk_clear_pulses: assert property ($rose(s_axi_bvalid) && wr_ctrl |-> {bt_count_clear, div_clear} == wd_q[1:0])
		else $error("clear pulses do not follow written bits");
	chk_cnt_zero: assert property (bt_count_clear |=> bt_count == '0)
		else $error("counter not zero after clear");
	chk_cnt_once: assert property (bt_count_clear |=> !bt_count_clear)
		else $error("counter clear longer than one cycle");
	chk_div_zero: assert property (div_clear |=> div_count == '0 && div_tick == 4'h0)
		else $error("divider or ticks not zero after clear");
	chk_div_once: assert property (div_clear |=> !div_clear)
		else $error("divider clear longer than one cycle");
	chk_pulse_cause: assert property (bt_count_clear || div_clear |-> $rose(s_axi_bvalid) && wr_ctrl)
		else $error("clear pulse without a control write");
	chk_read_bits: assert property (s_axi_rvalid && rd_ctrl |-> s_axi_rdata[1:0] == 2'b00 && s_axi_rdata[31:8] == '0)
		else $error("control read shows strobe or upper bits");
endmodule
bind btw_top btw_top_monitor #(.ADDR_W(ADDR_W), .CNT_W(CNT_W), .DIV_W(DIV_W)) u_mon (.*);

// *** test_btw_top.sv ***
// Self-checking bench for the basic timer and watchdog control block.
`timescale 1ns/1ps
`include "btw_defines.svh"
module test_btw_top;
	import btw_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1;
	logic        s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        wdt_enable, bt_count_clear, div_clear;
	btw_clksel_e bt_clk_sel;
	logic [7:0]  bt_count;
	logic [11:0] div_count;
	logic [3:0]  div_tick;
	logic [31:0] rd;
	logic [1:0]  rsp;
	int          bad_count = 0;
	int          samples_checked = 0;

	always #50 ref_clk = ~ref_clk;

	btw_top DUT (.*);

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Ready and valid are read at the edge itself, so they carry the values of the cycle that ends there.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (n < 50) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				n = 99;
			end
		end
		if (n != 99) chk("write answer", 0, 1);
		#1;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (n < 50) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				n = 99;
			end
		end
		if (n != 99) chk("read answer", 0, 1);
		#1;
	endtask

	task automatic t_reset(input bit pulse);
		if (pulse) begin
			wr(8'hDC, 8'hAC, 4'hF, rsp);
			chk("wdt off before reset", wdt_enable, 0);
			chk("sel before reset", bt_clk_sel, 3);
			@(posedge ref_clk);
			rst <= 1'b1;
			repeat (2) @(posedge ref_clk);
			rst <= 1'b0;
		end
		rdr(8'hDC, rd, rsp);
		chk("ctrl after reset", rd, 32'h0);
		chk("wdt after reset", wdt_enable, 1);
		chk("sel after reset", bt_clk_sel, 0);
		$display("reset test done");
	endtask

	task automatic t_wdt;
		for (int i = 0; i < 16; i++) begin
			wr(8'hDC, {i[3:0], 4'h0}, 4'hF, rsp);
			chk("wdt enable", wdt_enable, (i != 10));
			rdr(8'hDC, rd, rsp);
			chk("ctrl readback", rd, {24'h0, i[3:0], 4'h0});
		end
		$display("watchdog code test done");
	endtask

	task automatic t_sel;
		for (int i = 0; i < 4; i++) begin
			wr(8'hDC, {4'h0, i[1:0], 2'b00}, 4'hF, rsp);
			chk("clock select", bt_clk_sel, i);
		end
		// At the fastest ratio, 48 clocks hold at least two ticks of 16.
		repeat (48) @(posedge ref_clk);
		#1;
		chk("counter runs at fxx/16", bt_count >= 8'h02, 1);
		$display("clock select test done");
	endtask

	task automatic t_clear;
		wr(8'hDC, 8'h0C, 4'hF, rsp);
		chk("counter kept on zero bit", bt_count != 8'h00, 1);
		wr(8'hDC, 8'h0E, 4'hF, rsp);
		chk("counter cleared", bt_count, 0);
		rdr(8'hDC, rd, rsp);
		chk("counter clear bit reads zero", rd, 32'h0C);
		wr(8'hDC, 8'h0C, 4'hF, rsp);
		chk("divider kept on zero bit", div_count != 12'h000, 1);
		wr(8'hDC, 8'h0D, 4'hF, rsp);
		chk("divider cleared", div_count, 0);
		chk("shared ticks quiet", div_tick, 0);
		rdr(8'hDC, rd, rsp);
		chk("divider clear bit reads zero", rd, 32'h0C);
		$display("clear strobe test done");
	endtask

	task automatic t_err;
		wr(8'h40, 8'hA0, 4'hF, rsp);
		chk("unmapped write resp", rsp, `BTW_RESP_SLVERR);
		rdr(8'h40, rd, rsp);
		chk("unmapped read resp", rsp, `BTW_RESP_SLVERR);
		chk("unmapped read data", rd, 0);
		wr(8'hDC, 8'hA0, 4'h0, rsp);
		chk("no strobe resp", rsp, `BTW_RESP_OKAY);
		wr(8'hE0, 8'h55, 4'hF, rsp);
		chk("status write resp", rsp, `BTW_RESP_OKAY);
		rdr(8'hE0, rd, rsp);
		chk("status read resp", rsp, `BTW_RESP_OKAY);
		chk("status watchdog bit", rd[31:8], 24'h000001);
		rdr(8'hDC, rd, rsp);
		chk("ctrl unchanged", rd, 32'h0C);
		$display("error test done");
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#1000000;
		bad_count++;
		test_done;
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset(0);
		t_wdt;
		t_sel;
		t_clear;
		t_err;
		t_reset(1);
		test_done;
	end
endmodule
